/* rtl/tec_pkg.sv */
package tec_pkg;
	// register byte addresses on the apb side
	localparam logic [7:0] TEC_T0_LOW_ADDR = 8'h00;
	localparam logic [7:0] TEC_T0_HIGH_ADDR = 8'h04;
	localparam logic [7:0] TEC_T0_CTRL_ADDR = 8'h08;
	localparam logic [7:0] TEC_T1_LOW_ADDR = 8'h0C;
	localparam logic [7:0] TEC_T1_HIGH_ADDR = 8'h10;
	localparam logic [7:0] TEC_T1_CTRL_ADDR = 8'h14;
	localparam logic [7:0] TEC_STATUS_ADDR = 8'h18;
	// control register field positions
	localparam int TEC_MODE_HI_BIT = 7;
	localparam int TEC_MODE_LO_BIT = 6;
	localparam int TEC_RUN_BIT = 4;
	localparam int TEC_EDGE_BIT = 3;
	localparam int TEC_PRESCALE_LSB = 0;
	localparam int TEC_PRESCALE_W = 3;
	// reset values and count limit
	localparam logic [7:0] TEC_CTRL_RESET = 8'h00;
	localparam logic [15:0] TEC_COUNT_RESET = 16'h0000;
	localparam logic [15:0] TEC_COUNT_MAX = 16'hFFFF;
	// internal count clock is the system clock divided by this
	localparam int TEC_SYS_DIV = 4;

	typedef enum logic [1:0] {
		TEC_MODE_IDLE = 2'b00,
		TEC_MODE_EVENT = 2'b01,
		TEC_MODE_TIMER = 2'b10,
		TEC_MODE_PULSE = 2'b11
	} tec_mode_type;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [7:0] wdata;
		logic access;
	} tec_req_type;
endpackage

/* rtl/tec_timer_pair.sv */
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - counter adds one per qualifying internal tick or selected pin edge
// - past FFFF the counter overflows, flags, reloads from preload, continues
// - preload write while stopped also loads the counter immediately
// - preload write while running waits for next overflow to reach counter
// - low byte write only fills the low holding buffer
// - high byte write loads high byte and moves buffered low byte
// - high byte read latches live low byte; low reads return latch
// - control bit 4 runs the counter when set, stops it when clear
// - mode 10 is timer mode counting sys clock divided by four
// - mode 11 is pulse width mode using sys clock divided by four
// - event mode counts pin transitions directly, no prescaler
// - event mode counts rising edges if edge bit 3 zero, else falling
// - event counting and overflow wake continue while processor powered down
// - pulse mode enable only arms; counting starts on active edge
// - edge zero pulse mode: start on fall, stop and clear on rise
// - edge one pulse mode: start on rise, stop and clear on fall
// - timer and event modes never clear the enable bit in hardware
// - after auto clear, pin ignored and count held until re-enabled
// - timer1 three-bit prescale field selects division stages of its clock
// - overflow sets request flag regardless of enable; wake even if masked
// - count clock inhibited during counter read or preload write
module tec_timer_pair
	import tec_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer0_event_pin,
	input wire logic timer1_event_pin,
	input wire logic powerDown,
	output logic timer0OverflowIrq,
	output logic timer1OverflowIrq,
	output logic wakeUp
);

	//////////////////////////////////////////////////////////////////////////
	// bus decode
	tec_req_type req;
	assign req.addr = paddr;
	assign req.write = pwrite;
	assign req.wdata = pwdata[7:0];
	assign req.access = psel & penable;
	assign pready = 1'b1;

	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a == TEC_T0_LOW_ADDR) || (a == TEC_T0_HIGH_ADDR) ||
			(a == TEC_T0_CTRL_ADDR) || (a == TEC_T1_LOW_ADDR) ||
			(a == TEC_T1_HIGH_ADDR) || (a == TEC_T1_CTRL_ADDR) ||
			(a == TEC_STATUS_ADDR);
	endfunction

	function automatic logic hit(input tec_req_type r, input logic [7:0] a,
		input logic w);
		hit = r.access && (r.addr == a) && (r.write == w);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// shared internal tick: sys clock divided by four
	logic [1:0] divCnt_r;
	logic sysTick;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			divCnt_r <= 2'h0;
		end else begin
			divCnt_r <= divCnt_r + 2'h1;
		end
	end
	assign sysTick = (divCnt_r == 2'(TEC_SYS_DIV - 1));

	// timer1 prescaler: 2^n stages of the divided clock
	logic [15:0] preCnt_r;
	logic [7:0] ctrl_r [2];
	logic [2:0] preSel;
	logic preTick;
	assign preSel = ctrl_r[1][TEC_PRESCALE_LSB +: TEC_PRESCALE_W];
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			preCnt_r <= 16'h0000;
		end else if (sysTick) begin
			preCnt_r <= preCnt_r + 16'h0001;
		end
	end
	// stage n fires when the low n bits of the prescale count wrap
	assign preTick = sysTick &&
		((preCnt_r & ((16'h0001 << preSel) - 16'h0001)) == 16'h0000);

	//////////////////////////////////////////////////////////////////////////
	// per-timer state
	logic [COUNT_W-1:0] count_r [2];
	logic [COUNT_W-1:0] preload_r [2];
	logic [7:0] lowBuf_r [2];
	logic [1:0] pinPrev_r;
	logic [1:0] pulseActive_r;
	logic [1:0] ovf;
	logic [1:0] pins;
	assign pins = {timer1_event_pin, timer0_event_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tmr
			localparam logic [7:0] LOW_A = gi ? TEC_T1_LOW_ADDR : TEC_T0_LOW_ADDR;
			localparam logic [7:0] HIGH_A = gi ? TEC_T1_HIGH_ADDR : TEC_T0_HIGH_ADDR;
			localparam logic [7:0] CTRL_A = gi ? TEC_T1_CTRL_ADDR : TEC_T0_CTRL_ADDR;
			tec_mode_type mode;
			logic run, edgeSel, rise, fall, startEdge, endEdge, intTick;
			logic inhibit, tick, wrLow, wrHigh, rdHigh, rdLow, wrCtrl, autoClr;
			logic [COUNT_W-1:0] newPreload;

			assign mode = tec_mode_type'(ctrl_r[gi][TEC_MODE_HI_BIT:TEC_MODE_LO_BIT]);
			assign run = ctrl_r[gi][TEC_RUN_BIT];
			assign edgeSel = ctrl_r[gi][TEC_EDGE_BIT];
			assign rise = pins[gi] & ~pinPrev_r[gi];
			assign fall = ~pins[gi] & pinPrev_r[gi];
			assign intTick = gi ? preTick : sysTick;
			assign wrLow = hit(req, LOW_A, 1'b1);
			assign wrHigh = hit(req, HIGH_A, 1'b1);
			assign rdHigh = hit(req, HIGH_A, 1'b0);
			assign rdLow = hit(req, LOW_A, 1'b0);
			assign wrCtrl = hit(req, CTRL_A, 1'b1);
			// a count can be lost here; accepted to keep reads coherent
			assign inhibit = wrHigh | rdHigh | rdLow;
			// pulse mode: edge zero opens on fall, edge one opens on rise
			assign startEdge = edgeSel ? rise : fall;
			assign endEdge = edgeSel ? fall : rise;

			always_comb begin
				tick = 1'b0;
				autoClr = 1'b0;
				unique case (mode)
					TEC_MODE_TIMER: tick = run & intTick;
					// direct pin edges, runs regardless of power down
					TEC_MODE_EVENT: tick = run & (edgeSel ? fall : rise);
					TEC_MODE_PULSE: begin
						tick = run & pulseActive_r[gi] & sysTick;
						autoClr = run & pulseActive_r[gi] & endEdge;
					end
					TEC_MODE_IDLE: tick = 1'b0;
				endcase
				tick = tick & ~inhibit;
			end
			assign ovf[gi] = tick && (count_r[gi] == TEC_COUNT_MAX);
			assign newPreload = {req.wdata, lowBuf_r[gi]};

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					pinPrev_r[gi] <= 1'b0;
				end else begin
					pinPrev_r[gi] <= pins[gi];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					pulseActive_r[gi] <= 1'b0;
				end else if (mode != TEC_MODE_PULSE || !run || autoClr) begin
					pulseActive_r[gi] <= 1'b0;
				end else if (startEdge) begin
					pulseActive_r[gi] <= 1'b1;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					ctrl_r[gi] <= TEC_CTRL_RESET;
				end else if (wrCtrl) begin
					ctrl_r[gi] <= req.wdata;
				end else if (autoClr) begin
					// only pulse mode gets here; other modes keep the bit
					ctrl_r[gi][TEC_RUN_BIT] <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					lowBuf_r[gi] <= 8'h00;
				end else if (wrLow) begin
					lowBuf_r[gi] <= req.wdata;
				end else if (rdHigh) begin
					lowBuf_r[gi] <= count_r[gi][7:0];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					preload_r[gi] <= TEC_COUNT_RESET;
				end else if (wrHigh) begin
					preload_r[gi] <= newPreload;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					count_r[gi] <= TEC_COUNT_RESET;
				end else if (wrHigh && !run) begin
					count_r[gi] <= newPreload;
				end else if (ovf[gi]) begin
					count_r[gi] <= preload_r[gi];
				end else if (tick) begin
					count_r[gi] <= count_r[gi] + COUNT_W'(1);
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// overflow request flags, set regardless of enable, set beats clear
	logic [1:0] ovfFlag_r;
	logic wrStatus;
	assign wrStatus = hit(req, TEC_STATUS_ADDR, 1'b1);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ovfFlag_r <= 2'b00;
		end else begin
			ovfFlag_r <= (ovfFlag_r & ~({2{wrStatus}} & req.wdata[1:0])) |
				ovf;
		end
	end
	assign timer0OverflowIrq = ovfFlag_r[0];
	assign timer1OverflowIrq = ovfFlag_r[1];

	logic wake_r;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= powerDown & (|ovf);
		end
	end
	assign wakeUp = wake_r;

	//////////////////////////////////////////////////////////////////////////
	// read data, registered one cycle ahead is not needed: zero-wait slave
	logic [7:0] rdByte;
	always_comb begin
		rdByte = 8'h00;
		unique case (paddr)
			TEC_T0_LOW_ADDR: rdByte = lowBuf_r[0];
			TEC_T0_HIGH_ADDR: rdByte = count_r[0][15:8];
			TEC_T0_CTRL_ADDR: rdByte = ctrl_r[0];
			TEC_T1_LOW_ADDR: rdByte = lowBuf_r[1];
			TEC_T1_HIGH_ADDR: rdByte = count_r[1][15:8];
			TEC_T1_CTRL_ADDR: rdByte = ctrl_r[1];
			TEC_STATUS_ADDR: rdByte = {6'h00, ovfFlag_r};
			default: rdByte = 8'h00;
		endcase
	end
	assign prdata = {24'h00_0000, rdByte};
	assign pslverr = req.access & ~isMapped(paddr);

endmodule // tec_timer_pair

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import tec_pkg::*;
;
	localparam logic [7:0] L0 = TEC_T0_LOW_ADDR;
	localparam logic [7:0] H0 = TEC_T0_HIGH_ADDR;
	localparam logic [7:0] C0 = TEC_T0_CTRL_ADDR;
	localparam logic [7:0] L1 = TEC_T1_LOW_ADDR;
	localparam logic [7:0] H1 = TEC_T1_HIGH_ADDR;
	localparam logic [7:0] C1 = TEC_T1_CTRL_ADDR;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic powerDown = 0, lastErr, pready, pslverr, pin0, pin1;
	logic irq0, irq1, wakeUpW, wakeSeen = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	int error_cnt = 0, cmp_count = 0;
	tec_timer_pair tec_timer_pair_inst(.sys_clk(sys_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer0_event_pin(pin0),
		.timer1_event_pin(pin1), .powerDown(powerDown),
		.timer0OverflowIrq(irq0), .timer1OverflowIrq(irq1),
		.wakeUp(wakeUpW));
	// wake is a one-cycle pulse, so keep a sticky copy for later compare
	always @(posedge sys_clk) begin
		if (wakeUpW === 1'b1)
			wakeSeen <= 1'b1;
	end
	tec_pin_src tec_pin_src_inst(.sys_clk(sys_clk), .pin0(pin0), .pin1(pin1));
	initial forever #20 sys_clk = ~sys_clk;
	//////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 8'h00, r);
		chk(r, exp);
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] v;
		int i;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(C0, 32'h0000_0000);
		rd(8'h1C, 32'h0000_0000);
		chk({31'h0, lastErr}, 32'h0000_0001);
		wr(L0, 8'h34);
		wr(H0, 8'h12);
		wr(L0, 8'h55);
		rd(H0, 32'h0000_0012);
		rd(L0, 32'h0000_0034);
		wr(L0, 8'hF0);
		wr(H0, 8'hFF);
		wr(C0, 8'h80);
		powerDown <= 1'b1;
		wr(C0, 8'h90);
		wr(L0, 8'h00);
		wr(H0, 8'h10);
		rd(H0, 32'h0000_00FF);
		rd(C0, 32'h0000_0090);
		v = 0;
		for (i = 0; i < 100 && v[0] !== 1'b1; i++)
			apb(1'b0, TEC_STATUS_ADDR, 8'h00, v);
		chk(v[0], 1);
		chk({31'h0, irq0}, 32'h0000_0001);
		chk({31'h0, wakeSeen}, 32'h0000_0001);
		chk({31'h0, irq1}, 32'h0000_0000);
		rd(H0, 32'h0000_0010);
		wr(TEC_STATUS_ADDR, 8'h01);
		rd(TEC_STATUS_ADDR, 32'h0000_0000);
		chk({31'h0, irq0}, 32'h0000_0000);
		powerDown <= 1'b0;
		wr(C0, 8'hC0);
		wr(L0, 8'h00);
		wr(H0, 8'h00);
		wr(C0, 8'hD0);
		tec_pin_src_inst.toggle(0, 1);
		rd(H0, 32'h0000_0000);
		rd(L0, 32'h0000_0000);
		tec_pin_src_inst.toggle(0, 1);
		repeat (40) @(posedge sys_clk);
		tec_pin_src_inst.toggle(0, 1);
		rd(C0, 32'h0000_00C0);
		rd(H0, 32'h0000_0000);
		apb(1'b0, L0, 8'h00, v);
		chk({31'h0, v inside {[8:13]}}, 32'h0000_0001);
		tec_pin_src_inst.toggle(0, 2);
		rd(H0, 32'h0000_0000);
		rd(L0, v);
		wr(C1, 8'h40);
		wr(C1, 8'h50);
		tec_pin_src_inst.toggle(1, 5);
		wr(C1, 8'h48);
		rd(H1, 32'h0000_0000);
		rd(L1, 32'h0000_0003);
		wr(C1, 8'h58);
		tec_pin_src_inst.toggle(1, 3);
		wr(C1, 8'h48);
		rd(H1, 32'h0000_0000);
		rd(L1, 32'h0000_0005);
		end_of_test;
	end
	// no test here should come near ten thousand clocks
	initial begin
		#400000;
		error_cnt++;
		$display("ERROR %0t watchdog expired", $time);
		end_of_test;
	end
endmodule // tb_top

/* tb/tec_pin_src.sv */
`timescale 1ns/1ps
module tec_pin_src (
	input wire logic sys_clk,
	output logic pin0,
	output logic pin1
);
	initial begin
		pin0 = 1'b0;
		pin1 = 1'b0;
	end
	// spaced four clocks so each edge survives the input sync
	task toggle(input int which, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			if (which == 1)
				pin1 <= ~pin1;
			else
				pin0 <= ~pin0;
			repeat (3) @(posedge sys_clk);
		end
	endtask
endmodule // tec_pin_src

/* tb/tec_timer_pair_asserts.sv */
`timescale 1ns/1ps
module tec_timer_pair_asserts
	import tec_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic powerDown,
	input wire logic timer0OverflowIrq,
	input wire logic timer1OverflowIrq,
	input wire logic wakeUp
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic acc;
	logic bad;
	logic clr0;
	assign acc = psel && penable;
	assign bad = paddr > TEC_STATUS_ADDR || paddr[1:0] != 2'b00;
	assign clr0 = acc && pwrite && paddr == TEC_STATUS_ADDR && pwdata[0];
	//////////////////////////////////////////////////////////////////////
	// flag and wake are registered on the same edge; the range allows one cycle of margin
	sequence s_ovf_pd;
		$past(powerDown) && $rose(timer0OverflowIrq);
	endsequence
	a_ready_high: assert property (acc |-> pready)
		else $error("pready low in access");
	a_unmapped_err: assert property (acc && bad |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && !bad |-> !pslverr)
		else $error("mapped access refused");
	a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_wake_pulse: assert property (wakeUp |=> !wakeUp)
		else $error("wake longer than one cycle");
	a_wake_cause: assert property (wakeUp |-> $past(powerDown))
		else $error("wake without power down");
	a_wake_on_ovf: assert property (s_ovf_pd |-> ##[0:1] wakeUp)
		else $error("overflow in power down gave no wake");
	a_flag_sticky: assert property (timer0OverflowIrq && !clr0 |=>
		timer0OverflowIrq)
		else $error("overflow flag dropped");
	a_status_read: assert property (acc && !pwrite &&
		paddr == TEC_STATUS_ADDR |-> prdata[1:0] ==
		{timer1OverflowIrq, timer0OverflowIrq})
		else $error("status read mismatch");
endmodule // tec_timer_pair_asserts

bind tec_timer_pair tec_timer_pair_asserts tec_timer_pair_asserts_inst(
	.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .powerDown(powerDown),
	.timer0OverflowIrq(timer0OverflowIrq),
	.timer1OverflowIrq(timer1OverflowIrq), .wakeUp(wakeUp));
